// [hw/pdi_pkg.sv]
package pdi_pkg;

	localparam int NRAIL = 4;
	localparam int LINREG_BASE = 2;
	localparam int CLK_HZ = 20000000;
	localparam int SHORT_TIME_MS = 1;
	localparam int SHORT_CYC = SHORT_TIME_MS * (CLK_HZ / 1000);
	localparam int GATE_TIME_US = 800;
	localparam int GATE_CYC = GATE_TIME_US * (CLK_HZ / 1000000);
	localparam int CNT_W = 16;

	localparam int FLAG_W = 19;
	localparam int F_CURLIM = 0;
	localparam int F_SHORT = 4;
	localparam int F_VCHG = 8;
	localparam int F_HOT = 12;
	localparam int F_OTEMP = 13;
	localparam int F_OVP = 14;
	localparam int F_PDROP = 15;
	localparam int F_SYNC = 16;
	localparam int F_MEAS = 17;
	localparam int F_RST = 18;
	localparam logic [FLAG_W-1:0] FLAG_MASKABLE = 19'h3900F;

	localparam logic POK_RESET = 1'b1;
	localparam logic MODE_GATED = 1'b0;

	typedef struct packed {
		logic [NRAIL-1:0] enable;
		logic [NRAIL-1:0] under;
		logic [NRAIL-1:0] over;
		logic [NRAIL-1:0] short_uv;
		logic [NRAIL-1:0] curlim;
	} pdi_rail_t;

	typedef struct packed {
		logic [NRAIL-1:0] monitor_sel;
		logic [1:0] window_sel;
		logic hot_warning_monitor_select;
		logic power_ok_pin_polarity;
		logic power_ok_open_drain_sel;
		logic [NRAIL-1:0] valid_rise_mask;
		logic [NRAIL-1:0] valid_fall_mask;
	} pdi_cfg_t;

	typedef struct packed {
		logic [NRAIL-1:0] curlim;
		logic [NRAIL-1:0] valid;
		logic hot_warning;
		logic overtemp_off;
		logic supply_overvolt;
		logic sync_clk;
		logic power_ok;
	} pdi_status_t;

	typedef enum logic {ST_LOAD, ST_RUN} pdi_state_t;

endpackage

// [hw/pdi_flag.sv]
`timescale 1ns/1ps
module pdi_flag #(
	parameter int W = 1
) (
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic init_i,
	input wire logic [W-1:0] set_i,
	input wire logic [W-1:0] clr_i,
	input wire logic [W-1:0] hold_i,
	output logic [W-1:0] flag_o
);
	logic [W-1:0] flag_reg;
	logic [W-1:0] flag_next;

	// Set beats clear; a live condition blocks the clear
	assign flag_next = set_i | (flag_reg & ~(clr_i & ~hold_i));
	assign flag_o = flag_reg;

	always_ff @(posedge clock_i) begin
		if (!resetn_i || init_i) begin
			flag_reg <= '0;
		end else begin
			flag_reg <= flag_next;
		end
	end
endmodule // pdi_flag

// [hw/pdi_top.sv]
`timescale 1ns/1ps
// Functional notes
// - irq_out_n_o low while any unmasked flag pending, released when all cleared.
// - After software or fault restart, raise reset flag unless reset mask set.
// - Reset mask reloads from OTP each reset; bus writes never touch it.
// - Buck current limit: maskable flag, live status; clear blocked while active.
// - Linear regulator current limit: same as buck, own flag and status.
// - Buck output low for 1 ms: disable converter, set unmaskable short flag.
// - Linear output low for 1 ms: disable regulator, set unmaskable short flag.
// - Thermal warning: maskable flag, live status, clear blocked while hot.
// - Thermal shutdown: disable all rails, outputs low, sticky unmaskable flag.
// - Supply overvoltage: disable all rails, outputs low, clear only after recovery.
// - Buck valid change flag on both directions, separate masks, validity status.
// - Linear valid change flag on both directions, separate masks, validity status.
// - Power-good drop sets maskable flag; status high means voltages valid.
// - Pin polarity inverts only the pin, never status or drop flag.
// - Sync clock change flag with status; measurement done flag without status.
// - Lockout reset clears everything silently; restart loads OTP, sets reset flag.
// - Software reset clears registers, restarts, then sets reset flag.
// - Each rail selectable as power-good source; disabled rails masked off.
// - Thermal warning optionally a power-good source; current limit never.
// - Power good only when every selected source and both faults are clear.
// - Window bit 0 checks undervoltage only, 1 checks both directions.
// - Pin polarity and push-pull or open-drain type are configurable.
// - Gated or continuous mode taken from OTP setting.
// - Gated mode holds power-good status 800 us after start-up or voltage change.
module pdi_top
	import pdi_pkg::*;
#(
	parameter int SHORT_CYCLES = SHORT_CYC,
	parameter int GATE_CYCLES = GATE_CYC
) (
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire pdi_rail_t rail_i,
	input wire pdi_cfg_t cfg_i,
	input wire logic hot_warning_i,
	input wire logic overtemp_i,
	input wire logic supply_overvolt_i,
	input wire logic sync_clk_present_i,
	input wire logic load_meas_done_i,
	input wire logic volt_change_i,
	input wire logic sw_reset_i,
	input wire logic otp_reset_mask_i,
	input wire logic otp_mode_i,
	input wire logic [FLAG_W-1:0] flag_mask_i,
	input wire logic [FLAG_W-1:0] flag_clear_i,
	output logic [FLAG_W-1:0] flag_o,
	output pdi_status_t status_o,
	output logic irq_out_n_o,
	output logic power_ok_pin_o,
	output logic power_ok_pin_oe_o,
	output logic [NRAIL-1:0] rail_off_o,
	output logic gpo_low_o
);
	pdi_state_t st_reg;
	pdi_state_t st_next;
	logic reset_mask_reg;
	logic mode_reg;
	logic restart_reg;
	logic [NRAIL-1:0] off_reg;
	logic [NRAIL-1:0] off_next;
	logic [CNT_W-1:0] short_cnt_reg [NRAIL];
	logic [NRAIL-1:0] valid_reg;
	logic [NRAIL-1:0] en_prev_reg;
	logic sync_reg;
	logic pok_reg;
	logic pok_next;
	logic [CNT_W-1:0] gate_cnt_reg;
	logic [CNT_W-1:0] gate_cnt_next;

	logic run;
	logic soft_clear;
	logic shutdown;
	logic [NRAIL-1:0] eff_en;
	logic [NRAIL-1:0] short_trip;
	logic [NRAIL-1:0] window;
	logic [NRAIL-1:0] valid_now;
	logic [NRAIL-1:0] rail_ok;
	logic pok_raw;
	logic gate_start;
	logic gating;
	logic first_run;
	logic [FLAG_W-1:0] flag_set;
	logic [FLAG_W-1:0] flag_hold;
	logic [FLAG_W-1:0] irq_gate;

	// Start-up sequencing: one load cycle after any reset, then run
	assign run = (st_reg == ST_RUN);
	assign soft_clear = run && sw_reset_i;
	assign st_next = (st_reg == ST_LOAD) ? ST_RUN : (soft_clear ? ST_LOAD : ST_RUN);
	assign first_run = (st_reg == ST_LOAD);

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			st_reg <= ST_LOAD;
			reset_mask_reg <= 1'b0;
			mode_reg <= MODE_GATED;
			restart_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			restart_reg <= first_run;
			if (first_run) begin
				reset_mask_reg <= otp_reset_mask_i;
				mode_reg <= otp_mode_i;
			end
		end
	end

	// Faults that force every rail off
	assign shutdown = flag_o[F_OTEMP] || flag_o[F_OVP] || overtemp_i || supply_overvolt_i;
	assign rail_off_o = off_reg | {NRAIL{shutdown || !run}};
	assign gpo_low_o = shutdown || !run;
	assign eff_en = rail_i.enable & ~rail_off_o;

	// Short or overload debounce per rail
	genvar g;
	generate
		for (g = 0; g < NRAIL; g++) begin : g_rail
			assign short_trip[g] = eff_en[g] && rail_i.short_uv[g]
				&& (short_cnt_reg[g] == CNT_W'(SHORT_CYCLES - 1));
			assign window[g] = cfg_i.window_sel[(g >= LINREG_BASE) ? 1 : 0];
			always_ff @(posedge clock_i) begin
				if (!resetn_i || soft_clear || !eff_en[g] || !rail_i.short_uv[g]) begin
					short_cnt_reg[g] <= '0;
				end else if (!short_trip[g]) begin
					short_cnt_reg[g] <= short_cnt_reg[g] + CNT_W'(1);
				end
			end
		end
	endgenerate

	// Tripped rail stays off until its enable is dropped
	assign off_next = (off_reg & rail_i.enable) | short_trip;

	// Rail validity and power-good combine
	assign valid_now = eff_en & ~rail_i.under & ~(window & rail_i.over);
	assign rail_ok = ~cfg_i.monitor_sel | ~eff_en | valid_now;
	assign pok_raw = (&rail_ok)
		&& !(cfg_i.hot_warning_monitor_select && hot_warning_i)
		&& !flag_o[F_OVP] && !flag_o[F_OTEMP];

	// Gated mode freezes status after start-up or a requested change
	assign gate_start = (mode_reg == MODE_GATED)
		&& (restart_reg || volt_change_i || |(rail_i.enable & ~en_prev_reg));
	assign gating = (gate_cnt_reg != '0);
	assign gate_cnt_next = gate_start ? CNT_W'(GATE_CYCLES)
		: (gating ? gate_cnt_reg - CNT_W'(1) : '0);
	assign pok_next = gating ? pok_reg : pok_raw;

	always_ff @(posedge clock_i) begin
		if (!resetn_i || soft_clear) begin
			off_reg <= '0;
			valid_reg <= '0;
			en_prev_reg <= '0;
			sync_reg <= 1'b0;
			pok_reg <= POK_RESET;
			gate_cnt_reg <= '0;
		end else begin
			off_reg <= off_next;
			valid_reg <= valid_now;
			en_prev_reg <= rail_i.enable;
			sync_reg <= sync_clk_present_i;
			pok_reg <= first_run ? POK_RESET : pok_next;
			gate_cnt_reg <= gate_cnt_next;
		end
	end

	// Pin: polarity and driver type affect only the pin
	assign power_ok_pin_o = cfg_i.power_ok_open_drain_sel ? 1'b0
		: (pok_reg ~^ cfg_i.power_ok_pin_polarity);
	assign power_ok_pin_oe_o = cfg_i.power_ok_open_drain_sel
		? (pok_reg ^ cfg_i.power_ok_pin_polarity) : 1'b1;

	// Event sources for the sticky flags
	assign flag_set[F_CURLIM +: NRAIL] = {NRAIL{run}} & rail_i.curlim;
	assign flag_set[F_SHORT +: NRAIL] = short_trip;
	assign flag_set[F_VCHG +: NRAIL] = {NRAIL{run}}
		& ((valid_now & ~valid_reg & ~cfg_i.valid_rise_mask)
		| (~valid_now & valid_reg & ~cfg_i.valid_fall_mask));
	assign flag_set[F_HOT] = run && hot_warning_i;
	assign flag_set[F_OTEMP] = run && overtemp_i;
	assign flag_set[F_OVP] = run && supply_overvolt_i;
	assign flag_set[F_PDROP] = run && pok_reg && !pok_next;
	assign flag_set[F_SYNC] = run && (sync_reg != sync_clk_present_i);
	assign flag_set[F_MEAS] = run && load_meas_done_i;
	assign flag_set[F_RST] = restart_reg && !reset_mask_reg;

	assign flag_hold = '0 | (FLAG_W'(rail_i.curlim) << F_CURLIM)
		| (FLAG_W'(hot_warning_i) << F_HOT)
		| (FLAG_W'(overtemp_i) << F_OTEMP)
		| (FLAG_W'(supply_overvolt_i) << F_OVP);

	pdi_flag #(
		.W(FLAG_W)
	) u_flags (
		.clock_i(clock_i),
		.resetn_i(resetn_i),
		.init_i(soft_clear),
		.set_i(flag_set),
		.clr_i(flag_clear_i),
		.hold_i(flag_hold),
		.flag_o(flag_o)
	);

	assign irq_gate = ~(FLAG_MASKABLE & flag_mask_i);
	assign irq_out_n_o = !(|(flag_o & irq_gate));

	assign status_o.curlim = rail_i.curlim;
	assign status_o.valid = valid_reg;
	assign status_o.hot_warning = hot_warning_i;
	assign status_o.overtemp_off = overtemp_i;
	assign status_o.supply_overvolt = supply_overvolt_i;
	assign status_o.sync_clk = sync_reg;
	assign status_o.power_ok = pok_reg;

	sequence s_load_done;
		(st_reg == ST_LOAD) ##1 (st_reg == ST_RUN);
	endsequence

	a_irq_pending: assert property (@(posedge clock_i) disable iff (!resetn_i)
		|(flag_o & irq_gate) |-> !irq_out_n_o)
		else $error("interrupt line high with pending flag");
	a_reset_flag_set: assert property (@(posedge clock_i) disable iff (!resetn_i)
		s_load_done ##0 !reset_mask_reg |=> flag_o[F_RST])
		else $error("reset flag missing after start-up");
	a_mask_reload: assert property (@(posedge clock_i) disable iff (!resetn_i)
		first_run |=> reset_mask_reg == $past(otp_reset_mask_i))
		else $error("reset mask not reloaded");
	a_curlim_hold: assert property (@(posedge clock_i) disable iff (!resetn_i)
		run && !sw_reset_i && flag_o[F_CURLIM] && rail_i.curlim[0] |=> flag_o[F_CURLIM])
		else $error("buck limit flag cleared while active");
	a_linlim_hold: assert property (@(posedge clock_i) disable iff (!resetn_i)
		run && !sw_reset_i && flag_o[F_CURLIM + LINREG_BASE] && rail_i.curlim[LINREG_BASE]
		|=> flag_o[F_CURLIM + LINREG_BASE])
		else $error("linear limit flag cleared while active");
	a_short_trip: assert property (@(posedge clock_i) disable iff (!resetn_i)
		run && !sw_reset_i && short_trip[0] |=> off_reg[0] && flag_o[F_SHORT])
		else $error("buck short did not disable rail");
	a_lin_short: assert property (@(posedge clock_i) disable iff (!resetn_i)
		run && !sw_reset_i && short_trip[LINREG_BASE]
		|=> off_reg[LINREG_BASE] && flag_o[F_SHORT + LINREG_BASE])
		else $error("linear short did not disable rail");
	a_otemp_off: assert property (@(posedge clock_i) disable iff (!resetn_i)
		flag_o[F_OTEMP] |-> (&rail_off_o) && gpo_low_o && !pok_raw)
		else $error("thermal shutdown left rails on");
	a_ovp_off: assert property (@(posedge clock_i) disable iff (!resetn_i)
		run && !sw_reset_i && flag_o[F_OVP] && supply_overvolt_i |=> flag_o[F_OVP] && gpo_low_o)
		else $error("overvoltage flag lost or outputs high");
	a_pok_drop: assert property (@(posedge clock_i) disable iff (!resetn_i)
		run && !sw_reset_i && pok_reg && !pok_next |=> !pok_reg && flag_o[F_PDROP])
		else $error("power-good drop flag missing");
	a_pin_sense: assert property (@(posedge clock_i) disable iff (!resetn_i)
		!cfg_i.power_ok_open_drain_sel |-> power_ok_pin_o == (cfg_i.power_ok_pin_polarity
		? pok_reg : !pok_reg))
		else $error("pin polarity wrong");
	a_gate_hold: assert property (@(posedge clock_i) disable iff (!resetn_i)
		run && !sw_reset_i && gating |=> $stable(pok_reg))
		else $error("status changed during gate period");
	a_write_zero: assert property (@(posedge clock_i) disable iff (!resetn_i)
		run && !sw_reset_i && flag_o[F_MEAS] && !flag_clear_i[F_MEAS] |=> flag_o[F_MEAS])
		else $error("flag lost without a clear");
endmodule // pdi_top

// [testbench/pdi_host.sv]
`timescale 1ns/1ps
module pdi_host
	import pdi_pkg::*;
(
	input wire logic clock_i,
	output logic [FLAG_W-1:0] flag_mask_o,
	output logic [FLAG_W-1:0] flag_clear_o
);
	initial begin
		flag_mask_o = '0;
		flag_clear_o = '0;
	end
	// One write cycle; zero bits leave their flags alone
	task automatic clear(input logic [FLAG_W-1:0] bits);
		@(posedge clock_i);
		#1 flag_clear_o = bits;
		@(posedge clock_i);
		#1 flag_clear_o = '0;
	endtask
	task automatic mask(input logic [FLAG_W-1:0] bits);
		@(posedge clock_i);
		#1 flag_mask_o = bits;
	endtask
endmodule // pdi_host

// [testbench/tb_pdi_top.sv]
`timescale 1ns/1ps
module tb_pdi_top import pdi_pkg::*;;
	localparam int SC = 8;
	logic clock_i = 1'b0;
	logic resetn_i, hot, otemp, ovolt, sync, meas, swr, otpm;
	pdi_rail_t rail;
	pdi_cfg_t cfg;
	pdi_status_t st;
	logic [FLAG_W-1:0] fmask, fclr, flag;
	logic irq_n, pin, pin_oe, gpo_low, mode, vchg;
	logic [NRAIL-1:0] roff;
	int n_errors = 0;
	int checked = 0;
	int cycles = 0;
	int fb[5] = '{F_CURLIM, F_CURLIM + 2, F_HOT, F_OTEMP, F_OVP};
	always #25 clock_i = ~clock_i;
	pdi_top #(.SHORT_CYCLES(SC), .GATE_CYCLES(4)) u_pdi_top (.clock_i(clock_i),
		.resetn_i(resetn_i), .rail_i(rail), .cfg_i(cfg), .hot_warning_i(hot),
		.overtemp_i(otemp), .supply_overvolt_i(ovolt), .sync_clk_present_i(sync),
		.load_meas_done_i(meas), .volt_change_i(vchg), .sw_reset_i(swr),
		.otp_reset_mask_i(otpm), .otp_mode_i(mode), .flag_mask_i(fmask),
		.flag_clear_i(fclr), .flag_o(flag), .status_o(st), .irq_out_n_o(irq_n),
		.power_ok_pin_o(pin), .power_ok_pin_oe_o(pin_oe), .rail_off_o(roff),
		.gpo_low_o(gpo_low));
	pdi_host u_pdi_host (.clock_i(clock_i), .flag_mask_o(fmask), .flag_clear_o(fclr));
	function automatic logic [FLAG_W-1:0] b(input int i);
		return 19'h00001 << i;
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic drive(input int k, input logic v);
		case (k)
			0: rail.curlim[0] = v;
			1: rail.curlim[2] = v;
			2: hot = v;
			3: otemp = v;
			default: ovolt = v;
		endcase
	endtask
	task automatic print_verdict;
		if (n_errors == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	always @(posedge clock_i) begin
		cycles++;
		if (cycles == 5000) begin
			n_errors++;
			print_verdict();
		end
	end
	initial begin
		resetn_i = 1'b0;
		rail = '0;
		cfg = '0;
		cfg.valid_rise_mask = 4'hF;
		cfg.valid_fall_mask = 4'hF;
		{hot, otemp, ovolt, sync, meas, swr, otpm, vchg} = '0;
		mode = 1'b1;
		repeat (16) @(posedge clock_i);
		#1 resetn_i = 1'b1;
		cyc(3);
		chk("reset flag", 1, flag[F_RST]);
		chk("irq low", 0, irq_n);
		u_pdi_host.clear(b(F_RST));
		chk("flags clear", 0, flag);
		chk("irq released", 1, irq_n);
		for (int m = 0; m < 2; m++) begin
			u_pdi_host.mask(m ? 19'h7FFFF : 19'h00000);
			for (int k = 0; k < 5; k++) begin
				drive(k, 1'b1);
				cyc(1);
				chk("live flag", b(fb[k]), flag);
				chk("irq mask", m && k < 3, irq_n);
				chk("live stat", 1, k == 0 ? st.curlim[0] : k == 1 ? st.curlim[2]
					: k == 2 ? st.hot_warning : k == 3 ? st.overtemp_off
					: st.supply_overvolt);
				if (k > 2) chk("rails off", 4'hF, {roff & 4'hF});
				if (k > 2) chk("gpo low", 1, gpo_low);
				// Faults also drop power-good; clear that flag alongside
				u_pdi_host.clear(b(fb[k]) | b(F_PDROP));
				chk("clear refused", b(fb[k]), flag);
				drive(k, 1'b0);
				u_pdi_host.clear(b(fb[k]));
				chk("cleared", 0, flag);
			end
		end
		u_pdi_host.mask(19'h00000);
		for (int r = 1; r < 4; r += 2) begin
			rail.enable[r] = 1'b1;
			rail.short_uv[r] = 1'b1;
			cyc(SC - 2);
			chk("short early", 0, flag[F_SHORT + r]);
			cyc(3);
			chk("short flag", 1, flag[F_SHORT + r]);
			chk("short off", 1, roff[r]);
			chk("short irq", 0, irq_n);
			rail.short_uv[r] = 1'b0;
			rail.enable[r] = 1'b0;
			u_pdi_host.clear(b(F_SHORT + r));
			chk("short clr", 0, flag);
		end
		cfg.monitor_sel = 4'h1;
		cfg.power_ok_pin_polarity = 1'b1;
		rail.enable[0] = 1'b1;
		rail.curlim[0] = 1'b1;
		cyc(3);
		chk("pok curlim", 1, st.power_ok);
		chk("pin high", 1, pin);
		rail.curlim[0] = 1'b0;
		rail.under[0] = 1'b1;
		cyc(3);
		chk("pok drop", 0, st.power_ok);
		chk("drop flag", b(F_PDROP) | b(F_CURLIM), flag);
		chk("pin low", 0, pin);
		cfg.power_ok_pin_polarity = 1'b0;
		cfg.power_ok_open_drain_sel = 1'b1;
		cyc(1);
		chk("pin released", 0, pin_oe);
		chk("pok sense", 0, st.power_ok);
		rail.enable[0] = 1'b0;
		cyc(3);
		chk("pok disabled", 1, st.power_ok);
		chk("pin pulled", 1, pin_oe);
		u_pdi_host.clear(b(F_PDROP));
		rail.enable[0] = 1'b1;
		rail.under[0] = 1'b0;
		rail.over[0] = 1'b1;
		cyc(3);
		chk("window off", 1, st.power_ok);
		cfg.window_sel = 2'h1;
		cyc(3);
		chk("window on", 0, st.power_ok);
		rail.over[0] = 1'b0;
		hot = 1'b1;
		cyc(3);
		chk("hot unselected", 1, st.power_ok);
		cfg.hot_warning_monitor_select = 1'b1;
		cyc(3);
		chk("hot selected", 0, st.power_ok);
		hot = 1'b0;
		u_pdi_host.clear(b(F_PDROP) | b(F_HOT));
		for (int r = 0; r < 4; r += 2) begin
			rail.enable[r] = 1'b1;
			cfg.valid_fall_mask = 4'(~b(r));
			cyc(1);
			rail.under[r] = 1'b1;
			cyc(3);
			chk("valid fall", 1, flag[F_VCHG + r]);
			chk("valid stat", 0, st.valid[r]);
			u_pdi_host.clear(b(F_VCHG + r));
			rail.under[r] = 1'b0;
			cyc(3);
			chk("rise masked", 0, flag[F_VCHG + r]);
			chk("valid back", 1, st.valid[r]);
		end
		u_pdi_host.clear(19'h7FFFF);
		sync = 1'b1;
		meas = 1'b1;
		cyc(1);
		meas = 1'b0;
		cyc(1);
		chk("sync meas", b(F_SYNC) | b(F_MEAS), flag);
		chk("sync stat", 1, st.sync_clk);
		u_pdi_host.mask(b(F_RST));
		swr = 1'b1;
		cyc(1);
		swr = 1'b0;
		cyc(5);
		chk("sw reset", b(F_RST), flag);
		otpm = 1'b1;
		mode = 1'b0;
		resetn_i = 1'b0;
		cyc(2);
		resetn_i = 1'b1;
		cyc(2);
		rail.under[0] = 1'b1;
		cyc(2);
		chk("gate hold", 1, st.power_ok);
		cyc(1);
		chk("otp mask", 0, flag[F_RST]);
		cyc(3);
		chk("gate end", 0, st.power_ok);
		vchg = 1'b1;
		cyc(1);
		vchg = 1'b0;
		rail.under[0] = 1'b0;
		cyc(2);
		chk("change hold", 0, st.power_ok);
		cyc(4);
		chk("change end", 1, st.power_ok);
		print_verdict();
	end
endmodule // tb_pdi_top
